// file: src/adc_dec_ctrl.sv
// Purpose: Record-path control: volume, mute, amp gains, polarity, filters
// Assumes: Comb-filter samples and output sink run on clk_i
// Notes: Wishbone classic slave, one wait state, 16-bit registers
// Operation
// - Volume code: two's complement half-dB, 0x80 silence
// - Volume register: left high byte, right low
// - Mute bit 15 silences output, resets clear
// - Left amplifier gain from bits 11..8
// - Right amplifier gain from bits 3..0
// - Amplifier code steps 3 dB up to 24
// - Polarity bit 12 inverts input samples
// - Bypass bit 1 skips offset filter, resets set
// - Offset filter sits before the decimator
// - High-pass bit 0 enables filter, resets set
// - High-pass blocks DC after decimation, once per sample
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/100ps
module adc_dec_ctrl #(
    parameter int DEC_LOG2 = 6 // Decimation ratio as power of two
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic in_valid_i,
    input wire adc_pkg::adc_smp_t in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output adc_pkg::adc_smp_t out_data_o,
    input wire logic out_ready_i,
    output logic [3:0] input_amp_gain_left_o,
    output logic [3:0] input_amp_gain_right_o,
    output logic [4:0] amp_db_left_o,
    output logic [4:0] amp_db_right_o,
    output logic record_path_silence_o
);
    localparam int SW = adc_pkg::SMP_W;
    localparam int AW = adc_pkg::ACC_W;
    localparam int DW = adc_pkg::SMP_W + DEC_LOG2;

    // ************************************************************
    // Functions
    // ************************************************************

    // Byte-lane merge of a register write
    function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
        input logic [3:0] sel, input logic [15:0] mask);
        logic [15:0] v;
        v = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
        return v & mask;
    endfunction

    // First-order DC blocker: input minus tracked mean
    function automatic logic signed [SW-1:0] dcb(input logic signed [SW-1:0] x,
        input logic signed [AW-1:0] a, input logic [4:0] k);
        logic signed [AW-1:0] t;
        t = AW'(x) - (a >>> k);
        return t[SW-1:0];
    endfunction

    // Half-dB volume: mantissa table plus shift
    function automatic logic signed [SW-1:0] vol_apply(input logic signed [SW-1:0] x,
        input logic [7:0] code);
        logic [7:0] c;
        logic [7:0] n;
        logic [3:0] q;
        logic [3:0] r;
        logic signed [SW+16:0] p;
        c = (!code[7] && code > adc_pkg::VOL_TOP) ? adc_pkg::VOL_TOP : code;
        n = adc_pkg::VOL_TOP - c;
        q = 4'(n / adc_pkg::VOL_STEPS_OCT);
        r = 4'(n % adc_pkg::VOL_STEPS_OCT);
        p = (SW+17)'(x) * $signed({1'b0, adc_pkg::VOL_MANT[r]});
        p = p >>> (adc_pkg::VOL_FRAC - adc_pkg::VOL_HEAD + 32'(q));
        if (code == adc_pkg::VOL_INF) begin
            return '0;
        end
        return p[SW-1:0];
    endfunction

    // Amplifier code to gain in dB, undefined codes clamp
    function automatic logic [4:0] amp_db(input logic [3:0] c);
        logic [3:0] v;
        v = (c > adc_pkg::AMP_MAX) ? adc_pkg::AMP_MAX : c;
        return 5'(v * adc_pkg::AMP_STEP_DB);
    endfunction

    // ************************************************************
    // Registers and bus slave
    // ************************************************************
    logic [15:0] vol_q; // Volume codes
    logic [15:0] mg_q; // Mute and amp gains
    logic [15:0] flt_q; // Polarity and filter control
    logic ack_q; // Bus answer
    logic [31:0] rd_q; // Read data
    logic [15:0] stat_w; // Live status
    logic req_w; // New bus request
    logic [5:0] idx_w; // Register index

    assign req_w = cyc_i && stb_i && !ack_q;
    assign idx_w = adr_i[7:2];

    // Control register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vol_q <= adc_pkg::VOL_RST;
            mg_q <= adc_pkg::MG_RST;
            flt_q <= adc_pkg::FLT_RST;
        end else if (ce_i && req_w && we_i) begin
            case (idx_w)
                adc_pkg::IDX_VOL: begin
                    vol_q <= wr16(vol_q, dat_i, sel_i, adc_pkg::VOL_MASK);
                end
                adc_pkg::IDX_MG: begin
                    mg_q <= wr16(mg_q, dat_i, sel_i, adc_pkg::MG_MASK);
                end
                adc_pkg::IDX_FLT: begin
                    flt_q <= wr16(flt_q, dat_i, sel_i, adc_pkg::FLT_MASK);
                end
                default: begin
                    // Unmapped or read-only: write ignored
                end
            endcase
        end
    end

    // Answer and read data, one wait state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rd_q <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_q <= req_w;
            case (idx_w)
                adc_pkg::IDX_VOL: rd_q <= {16'h0000, vol_q};
                adc_pkg::IDX_MG: rd_q <= {16'h0000, mg_q};
                adc_pkg::IDX_FLT: rd_q <= {16'h0000, flt_q};
                adc_pkg::IDX_STAT: rd_q <= {16'h0000, stat_w};
                default: rd_q <= 32'h0000_0000;
            endcase
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rd_q;

    // ************************************************************
    // Amplifier controls
    // ************************************************************
    logic [3:0] ampl_q; // Left amp code out
    logic [3:0] ampr_q; // Right amp code out
    logic [4:0] dbl_q; // Left gain in dB
    logic [4:0] dbr_q; // Right gain in dB
    logic mute_q; // Silence out

    // Register the amplifier settings toward the analog side
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ampl_q <= 4'h0;
            ampr_q <= 4'h0;
            dbl_q <= 5'h00;
            dbr_q <= 5'h00;
            mute_q <= 1'b0;
        end else if (ce_i) begin
            ampl_q <= mg_q[adc_pkg::MG_AMPL_LSB +: 4];
            ampr_q <= mg_q[adc_pkg::MG_AMPR_LSB +: 4];
            dbl_q <= amp_db(mg_q[adc_pkg::MG_AMPL_LSB +: 4]);
            dbr_q <= amp_db(mg_q[adc_pkg::MG_AMPR_LSB +: 4]);
            mute_q <= mg_q[adc_pkg::MG_MUTE_BIT];
        end
    end

    assign input_amp_gain_left_o = ampl_q;
    assign input_amp_gain_right_o = ampr_q;
    assign amp_db_left_o = dbl_q;
    assign amp_db_right_o = dbr_q;
    assign record_path_silence_o = mute_q;

    // ************************************************************
    // Input stage: polarity, offset filter, decimator
    // ************************************************************
    logic pol_w; // Invert input
    logic byp_w; // Skip offset filter
    logic hpon_w; // High-pass enabled
    logic in_rdy_q; // Room downstream
    logic fire_w; // Input word accepted
    logic last_w; // Final word of a decimation group
    logic push_w; // Decimated sample produced
    logic [DEC_LOG2-1:0] ph_q; // Decimation phase
    logic signed [SW-1:0] xl_w, xr_w; // After polarity
    logic signed [SW-1:0] dl_w, dr_w; // After offset filter
    logic signed [AW-1:0] dcl_q, dcr_q; // Offset trackers
    logic signed [DW-1:0] sl_q, sr_q; // Decimator sums
    logic signed [DW-1:0] snl_w, snr_w; // Sums with current word

    assign pol_w = flt_q[adc_pkg::FLT_POL_BIT];
    assign byp_w = flt_q[adc_pkg::FLT_BYP_BIT];
    assign hpon_w = flt_q[adc_pkg::FLT_HP_BIT];
    assign fire_w = ce_i && in_valid_i && in_rdy_q;
    assign last_w = &ph_q;
    assign push_w = fire_w && last_w;
    assign xl_w = pol_w ? -in_data_i.left : in_data_i.left;
    assign xr_w = pol_w ? -in_data_i.right : in_data_i.right;
    assign dl_w = byp_w ? xl_w : dcb(xl_w, dcl_q, adc_pkg::DC_K);
    assign dr_w = byp_w ? xr_w : dcb(xr_w, dcr_q, adc_pkg::DC_K);
    assign snl_w = sl_q + DW'(dl_w);
    assign snr_w = sr_q + DW'(dr_w);

    // Offset trackers run at the comb rate, ahead of decimation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dcl_q <= '0;
            dcr_q <= '0;
        end else if (fire_w && !byp_w) begin
            dcl_q <= dcl_q + AW'(dl_w);
            dcr_q <= dcr_q + AW'(dr_w);
        end
    end

    // Decimator: average of each group of input words
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_q <= '0;
            sl_q <= '0;
            sr_q <= '0;
        end else if (fire_w) begin
            ph_q <= ph_q + 1'b1;
            sl_q <= last_w ? '0 : snl_w;
            sr_q <= last_w ? '0 : snr_w;
        end
    end

    // ************************************************************
    // Output-rate stage: high-pass, volume, mute
    // ************************************************************
    logic signed [SW-1:0] avl_w, avr_w; // Decimated words
    logic signed [SW-1:0] hl_w, hr_w; // After high-pass
    logic signed [SW-1:0] yl_w, yr_w; // After volume
    logic signed [AW-1:0] hpl_q, hpr_q; // High-pass trackers
    adc_pkg::adc_smp_t new_w; // Word entering the buffer
    logic signed [DW-1:0] shl_w, shr_w; // Scaled sums

    assign shl_w = snl_w >>> DEC_LOG2;
    assign shr_w = snr_w >>> DEC_LOG2;
    assign avl_w = shl_w[SW-1:0];
    assign avr_w = shr_w[SW-1:0];
    assign hl_w = hpon_w ? dcb(avl_w, hpl_q, adc_pkg::HP_K) : avl_w;
    assign hr_w = hpon_w ? dcb(avr_w, hpr_q, adc_pkg::HP_K) : avr_w;
    assign yl_w = vol_apply(hl_w, vol_q[adc_pkg::VOL_L_LSB +: 8]);
    assign yr_w = vol_apply(hr_w, vol_q[adc_pkg::VOL_R_LSB +: 8]);
    // Silence replaces the word; filters above keep running
    assign new_w = mg_q[adc_pkg::MG_MUTE_BIT] ? '0 : adc_pkg::adc_smp_t'{left: yl_w, right: yr_w};

    // High-pass trackers step once per output sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hpl_q <= '0;
            hpr_q <= '0;
        end else if (push_w && hpon_w) begin
            hpl_q <= hpl_q + AW'(hl_w);
            hpr_q <= hpr_q + AW'(hr_w);
        end
    end

    // ************************************************************
    // Two-entry output buffer
    // ************************************************************
    adc_pkg::adc_smp_t out_q; // Head entry
    adc_pkg::adc_smp_t skid_q; // Second entry
    logic out_vld_q; // Head valid
    logic skid_vld_q; // Second valid
    logic pop_w; // Head taken by sink

    assign pop_w = out_vld_q && out_ready_i;

    // Head moves up from the second entry first; input stalls while full
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_q <= '0;
            skid_q <= '0;
            out_vld_q <= 1'b0;
            skid_vld_q <= 1'b0;
            in_rdy_q <= 1'b1;
        end else if (ce_i) begin
            if (pop_w || !out_vld_q) begin
                if (skid_vld_q) begin
                    out_q <= skid_q;
                    out_vld_q <= 1'b1;
                    skid_vld_q <= 1'b0;
                    in_rdy_q <= 1'b1;
                end else begin
                    out_q <= push_w ? new_w : out_q;
                    out_vld_q <= push_w;
                end
            end else if (push_w) begin
                skid_q <= new_w;
                skid_vld_q <= 1'b1;
                in_rdy_q <= 1'b0;
            end
        end
    end

    assign in_ready_o = in_rdy_q;
    assign out_valid_o = out_vld_q;
    assign out_data_o = out_q;
    assign stat_w = {13'h0000, mg_q[adc_pkg::MG_MUTE_BIT], skid_vld_q, out_vld_q};

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    chk_vol_silence: assert property (
        vol_q[15:8] == adc_pkg::VOL_INF |-> yl_w == '0)
        else $error("left volume code 0x80 did not silence");
    chk_vol_unity: assert property (
        vol_q[7:0] == 8'h00 |-> yr_w == hr_w)
        else $error("right volume code 0 is not unity gain");
    chk_vol_write: assert property (
        (req_w && we_i && idx_w == adc_pkg::IDX_VOL && sel_i[1:0] == 2'h3) |=>
        vol_q == $past(dat_i[15:0]))
        else $error("volume register write not stored");
    chk_mute_zero: assert property (
        (push_w && mg_q[15]) |=> (skid_vld_q ? skid_q == '0 : out_q == '0))
        else $error("muted sample not zero");
    chk_amp_left: assert property (
        $changed(mg_q[11:8]) |=> input_amp_gain_left_o == $past(mg_q[11:8]))
        else $error("left amplifier code not forwarded");
    chk_amp_right: assert property (
        $changed(mg_q[3:0]) |=> input_amp_gain_right_o == $past(mg_q[3:0]))
        else $error("right amplifier code not forwarded");
    chk_amp_db: assert property (
        input_amp_gain_left_o <= 4'h8 |-> amp_db_left_o == 5'(3 * input_amp_gain_left_o))
        else $error("left amplifier dB mapping wrong");
    chk_pol_inv: assert property (
        (pol_w && byp_w) |-> dl_w == -in_data_i.left)
        else $error("polarity inversion missing");
    chk_dc_bypass: assert property (
        (byp_w && !pol_w) |-> dr_w == in_data_i.right)
        else $error("offset filter not bypassed");
    chk_dc_hold: assert property (
        (byp_w && fire_w) |=> $stable(dcl_q))
        else $error("offset tracker moved while bypassed");
    chk_hp_off: assert property (
        !hpon_w |-> (hl_w == avl_w && hr_w == avr_w))
        else $error("high-pass active while disabled");
    chk_hp_rate: assert property (
        (!push_w && !rst_i) |=> $stable(hpl_q))
        else $error("high-pass tracker moved between samples");
    chk_bus_ack: assert property (
        req_w |=> ack_o ##1 !ack_o)
        else $error("bus answer not a single cycle");
endmodule

// file: src/adc_pkg.sv
// Purpose: Shared constants and types of the ADC record-path control block
// Assumes: 16-bit registers on a 32-bit Wishbone word, byte address = 4 * index
// Notes: Sample pairs travel as one packed struct
package adc_pkg;
    // ************************************************************
    // Sample format
    // ************************************************************
    localparam int SMP_W = 24; // Audio word width
    localparam int ACC_W = 40; // Filter accumulator width

    // ************************************************************
    // Register indices
    // ************************************************************
    localparam logic [5:0] IDX_VOL = 6'h20; // Channel volume codes
    localparam logic [5:0] IDX_MG = 6'h21; // Mute and amplifier gains
    localparam logic [5:0] IDX_FLT = 6'h22; // Polarity and filters
    localparam logic [5:0] IDX_STAT = 6'h23; // Stream status, read only

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int VOL_L_LSB = 8; // Left volume code
    localparam int VOL_R_LSB = 0; // Right volume code
    localparam int MG_MUTE_BIT = 15; // Record path silence
    localparam int MG_AMPL_LSB = 8; // Left amplifier code
    localparam int MG_AMPR_LSB = 0; // Right amplifier code
    localparam int FLT_POL_BIT = 12; // Input polarity invert
    localparam int FLT_BYP_BIT = 1; // Offset filter bypass
    localparam int FLT_HP_BIT = 0; // High-pass on

    // ************************************************************
    // Reset values and writable masks
    // ************************************************************
    localparam logic [15:0] VOL_RST = 16'h0000;
    localparam logic [15:0] MG_RST = 16'h0000;
    localparam logic [15:0] FLT_RST = 16'h0003;
    localparam logic [15:0] VOL_MASK = 16'hFFFF;
    localparam logic [15:0] MG_MASK = 16'h8F0F;
    localparam logic [15:0] FLT_MASK = 16'h1003;

    // ************************************************************
    // Gain coding
    // ************************************************************
    localparam logic [7:0] VOL_TOP = 8'h30; // +24 dB code
    localparam logic [7:0] VOL_INF = 8'h80; // Silence code
    localparam logic [7:0] VOL_STEPS_OCT = 8'h0C; // Half-dB steps per 6 dB
    localparam int VOL_FRAC = 15; // Mantissa fraction bits
    localparam int VOL_HEAD = 4; // Headroom shift for +24 dB
    localparam logic [3:0] AMP_MAX = 4'h8; // Highest defined amp code
    localparam logic [4:0] AMP_STEP_DB = 5'h03; // Amplifier step in dB
    localparam logic [4:0] DC_K = 5'h0A; // Offset filter pole shift
    localparam logic [4:0] HP_K = 5'h0C; // High-pass pole shift
    // Attenuation mantissas for 0 .. -5.5 dB in half-dB steps
    localparam logic [15:0] VOL_MANT [0:11] = '{16'h8000, 16'h78D7, 16'h7215, 16'h6BB3,
        16'h65AD, 16'h5FFD, 16'h5A9E, 16'h558C, 16'h50C3, 16'h4C3F, 16'h47FB, 16'h43F4};

    // Stereo sample pair
    typedef struct packed {
        logic signed [SMP_W-1:0] left;
        logic signed [SMP_W-1:0] right;
    } adc_smp_t;
endpackage

// file: tb/adc_src_model.sv
// Purpose: Behavioural comb-filter source feeding the record path
// Assumes: Shares the block clock, valid/ready handshake
// Notes: Left carries +level, right -level, random idle gaps
`timescale 1ns/100ps
module adc_src_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [7:0] words_i,
    input wire logic signed [23:0] level_i,
    input wire logic ready_i,
    output logic valid_o,
    output adc_pkg::adc_smp_t data_o,
    output logic busy_o
);
    // ********
    // Word sequencing
    // ********
    logic [7:0] left_q; // Words still to hand over
    logic [7:0] rem; // Count after this edge
    integer seed = 32'hB52E; // Fixed start for idle gaps
    assign busy_o = (left_q != 8'h00);
    // Quiet lines before the first edge
    initial begin
        valid_o = 1'b0;
        data_o = '0;
        left_q = 8'h00;
    end
    // Present a word, hold it until taken, then next word or idle
    always @(posedge clk_i) begin
        rem = left_q - {7'h00, valid_o & ready_i};
        if (rst_i) begin
            left_q <= 8'h00;
            valid_o <= 1'b0;
            data_o <= '0;
        end else if (start_i) begin
            left_q <= words_i;
        end else if (!(valid_o && !ready_i)) begin
            left_q <= rem;
            if (rem != 8'h00 && ($random(seed) & 3) != 0) begin
                valid_o <= 1'b1;
                data_o <= {level_i, -level_i};
            end else begin
                // Idle lines toggle so no stale word is seen
                valid_o <= 1'b0;
                data_o <= ~data_o;
            end
        end
    end
endmodule

// file: tb/adc_dec_ctrl_tb.sv
// Purpose: Self-checking bench of the record-path control block
// Assumes: Wishbone classic, decimation by 4 in simulation
// Notes: Drivers queue expected results, watchers compare them
`timescale 1ns/100ps
module adc_dec_ctrl_tb;
    // ********
    // Signals
    // ********
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h00000000;
    logic [31:0] dat_o;
    logic ack_o;
    logic in_valid_i;
    adc_pkg::adc_smp_t in_data_i;
    logic in_ready_o;
    logic out_valid_o;
    adc_pkg::adc_smp_t out_data_o;
    logic out_ready_i = 1'b0;
    logic [3:0] gain_l;
    logic [3:0] gain_r;
    logic [4:0] db_l;
    logic [4:0] db_r;
    logic silence;
    logic start_q = 1'b0; // Source start pulse
    logic [7:0] words = 8'h00; // Words per burst
    logic src_busy;
    logic hold_sink = 1'b0; // Sink stall request
    logic [3:0] note; // Channel modes: 0 any, 1 zero, 2 pos, 3 neg
    integer seed = 32'hB52E;
    int errors = 0;
    int cmp_count = 0;
    int cyc_n = 0;
    logic [31:0] rd_q[$];
    logic [3:0] smp_q[$];

    always #25 clk_i = ~clk_i;

    adc_dec_ctrl #(.DEC_LOG2(2)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .in_valid_i(in_valid_i), .in_data_i(in_data_i), .in_ready_o(in_ready_o),
        .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_ready_i(out_ready_i),
        .input_amp_gain_left_o(gain_l), .input_amp_gain_right_o(gain_r),
        .amp_db_left_o(db_l), .amp_db_right_o(db_r), .record_path_silence_o(silence));

    adc_src_model u_src (
        .clk_i(clk_i), .rst_i(rst_i), .start_i(start_q), .words_i(words), .level_i(24'h010000),
        .ready_i(in_ready_o), .valid_o(in_valid_i), .data_o(in_data_i), .busy_o(src_busy));

    // ********
    // Checking
    // ********
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Channel value against its mode
    task automatic chk_ch(input string nm, input logic [1:0] m, input logic signed [23:0] v);
        logic ok;
        ok = (m == 2'h0) || (m == 2'h1 && v === 24'h000000) || (m == 2'h2 && v > 24'sh000000)
            || (m == 2'h3 && v < 24'sh000000);
        if (m != 2'h0) cmp_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[FAIL] %s expected mode %0d seen %h", nm, m, v);
        end
    endtask
    function automatic logic [4:0] db(input logic [3:0] c);
        return (c > 4'h8) ? 5'h18 : {1'b0, c} * 5'h03;
    endfunction
    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Watch read answers and taken output pairs
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            if (rd_q.size() == 0) chk("read count", 32'h0, 32'h1);
            else chk("read data", rd_q.pop_front(), dat_o);
        end
        if (out_valid_o === 1'b1 && out_ready_i === 1'b1 && ce_i === 1'b1) begin
            if (smp_q.size() == 0) chk("sample count", 32'h0, 32'h1);
            else begin
                note = smp_q.pop_front();
                chk_ch("left sample", note[3:2], out_data_o.left);
                chk_ch("right sample", note[1:0], out_data_o.right);
            end
        end
    end
    // Random sink stalls and run ceiling
    always @(posedge clk_i) begin
        out_ready_i <= !hold_sink && (($random(seed) & 3) != 0);
        cyc_n++;
        if (cyc_n == 30000) begin
            errors++;
            $display("[FAIL] run length expected below 30000 seen %0d", cyc_n);
            stop_test();
        end
    end

    // ********
    // Drivers
    // ********
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {a[7:2], 2'($random(seed))};
        sel_i <= {2'($random(seed)), s[1:0]};
        dat_i <= {16'($random(seed)), d};
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20) chk("bus answer", 32'h1, 32'h0);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        rd_q.push_back({16'h0000, e});
        bus(1'b0, a, 16'h0000, 4'h3);
    endtask
    // Amplifier code written, codes and dB checked at the outputs
    task automatic amp(input logic [3:0] c);
        logic [3:0] r;
        r = 4'hF - c;
        bus(1'b1, 8'h84, {4'h0, c, 4'h0, r}, 4'h3);
        repeat (2) @(posedge clk_i);
        chk("amp code left", {28'h0, c}, {28'h0, gain_l}); // Left field
        chk("amp code right", {28'h0, r}, {28'h0, gain_r}); // Right field
        chk("amp db left", {27'h0, db(c)}, {27'h0, db_l}); // Left gain
        chk("amp db right", {27'h0, db(r)}, {27'h0, db_r}); // Right gain
    endtask
    // Burst of n words, first skip outputs unchecked
    task automatic send(input logic [7:0] n, input logic [3:0] m, input int skip, input bit blk);
        int t;
        for (int i = 0; i < n / 4; i++) smp_q.push_back(i < skip ? 4'h0 : m);
        words <= n;
        // An empty burst only drains; restarting would cut a stalled burst
        start_q <= (n != 8'h00);
        @(posedge clk_i);
        start_q <= 1'b0;
        t = 0;
        while (blk && (src_busy || smp_q.size() != 0) && t < 3000) begin
            @(posedge clk_i);
            t++;
        end
        if (t >= 3000) chk("stream drain", 32'h0, 32'(smp_q.size()));
    endtask

    // ********
    // Main sequence
    // ********
    initial begin
        int t;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("silence after reset", 32'h0, {31'h0, silence}); // Unmuted
        rd(8'h80, 16'h0000); // Volume default
        rd(8'h84, 16'h0000); // Gain default
        rd(8'h88, 16'h0003); // Filter default
        rd(8'h8C, 16'h0000);
        bus(1'b1, 8'hFC, 16'hFFFF, 4'h3);
        rd(8'hFC, 16'h0000);
        bus(1'b1, 8'h80, 16'hA55A, 4'h3);
        bus(1'b1, 8'h80, 16'h0000, 4'h1);
        rd(8'h80, 16'hA500); // Byte lanes
        bus(1'b1, 8'h84, 16'hFFFF, 4'h3);
        rd(8'h84, 16'h8F0F); // Fields
        chk("silence set", 32'h1, {31'h0, silence}); // Mute
        bus(1'b1, 8'h84, 16'h0000, 4'h2);
        rd(8'h84, 16'h000F); // High lane only
        chk("silence clear", 32'h0, {31'h0, silence}); // Unmute
        bus(1'b1, 8'h88, 16'hFFFF, 4'h3);
        rd(8'h88, 16'h1003); // Fields
        for (int c = 0; c < 16; c++) amp(4'(c)); // All codes
        bus(1'b1, 8'h80, 16'h0000, 4'h3);
        bus(1'b1, 8'h84, 16'h0000, 4'h3);
        bus(1'b1, 8'h88, 16'h0002, 4'h3);
        send(8'h10, 4'hB, 2, 1'b1); // DC passes
        bus(1'b1, 8'h88, 16'h1002, 4'h3);
        send(8'h10, 4'hE, 2, 1'b1); // Inverted
        bus(1'b1, 8'h88, 16'h0001, 4'h3);
        send(8'h10, 4'hB, 0, 1'b1); // Both filters on
        bus(1'b1, 8'h88, 16'h0002, 4'h3);
        bus(1'b1, 8'h84, 16'h8000, 4'h3);
        send(8'h10, 4'h5, 0, 1'b1); // Muted zeros
        bus(1'b1, 8'h84, 16'h0000, 4'h3);
        send(8'h10, 4'hB, 2, 1'b1); // Resumes
        bus(1'b1, 8'h80, 16'h8180, 4'h3);
        send(8'h10, 4'h9, 2, 1'b1); // Lowest step and silence
        bus(1'b1, 8'h80, 16'h8081, 4'h3);
        send(8'h10, 4'h7, 2, 1'b1); // Swapped codes
        bus(1'b1, 8'h80, 16'h0000, 4'h3);
        hold_sink <= 1'b1;
        send(8'h10, 4'hB, 2, 1'b0);
        t = 0;
        while (in_ready_o !== 1'b0 && t < 400) begin
            @(posedge clk_i);
            t++;
        end
        chk("input refused when full", 32'h0, {31'h0, in_ready_o});
        rd(8'h8C, 16'h0003);
        // Enable low: a ready sink must not pop the full buffer
        ce_i <= 1'b0;
        hold_sink <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("frozen by enable", 32'h2, {30'h0, out_valid_o, in_ready_o});
        ce_i <= 1'b1;
        send(8'h00, 4'h0, 0, 1'b1);
        repeat (2) @(posedge clk_i);
        chk("buffer empty", 32'h0, {31'h0, out_valid_o});
        stop_test();
    end
endmodule
